/* logic/ubdi_top.sv */
// Serial port: baud divider, register file, FIFOs, DMA requests, infrared endec.
// Assumes a classic Wishbone master and one 250 MHz clock.
// Summary of operation
// - 16-bit down counter reloads after 0001h, pulses
// - Each serial bit spans sixteen divider pulses
// - Divisor resets to 0002h, a pulse every second clock
// - Divisor byte write reloads counter, restarts count
// - Divisor bytes visible only while access bit set
// - Reset restores defaults and empties both FIFOs
// - Transmit-empty interrupt immediate; first write clears it
// - DMA enable bit turns on threshold requests
// - Transmit request while count at most threshold
// - Receive request while count nonzero and at least threshold
// - Infrared path half duplex, rate from divider
// - Encoder: one all low, zero 7-3-6
// - Decoder active when enabled, zero held low three clocks
// - Decoder drops pulses wider than five baud clocks
// - Narrow filter: 6-bit counter, field*4+3 cycles
// - Loopback bit routes encoder into decoder
// - Idle line high, LSB first, sixteen clocks
`timescale 1ns/1ns
`include "ubdi_consts.svh"
module ubdi_top
  import ubdi_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [5:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        SERIAL_IN_I,
  output logic             SERIAL_OUT_O,
  input  wire logic        OPTICAL_IN_I,
  output logic             OPTICAL_OUT_O,
  output logic             TX_EMPTY_IRQ_O,
  output logic             TX_DMA_REQ_O,
  output logic             RX_DMA_REQ_O
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  logic [15:0] divisor_reg;
  logic [15:0] baud_divider_reg;
  logic        tick_reg;
  logic [7:0]  line_control_reg;
  logic [7:0]  ien_reg;
  ubdi_fctl_s  fctl_reg;
  ubdi_irctl_s irctl_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  tx_mem [DEPTH];
  logic [7:0]  rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;
  logic        overrun_reg, frame_err_reg;
  ubdi_state_e tx_st_reg, rx_st_reg;
  logic [3:0]  tx_sub_reg, rx_sub_reg;
  logic [2:0]  tx_bit_reg, rx_bit_reg;
  logic [7:0]  tx_sh_reg, rx_sh_reg;
  logic        tx_line_reg;
  logic        opt_out_reg;
  logic        opt_prev_reg;
  logic [5:0]  np_cnt_reg;
  logic        np_ok_reg;
  logic [2:0]  width_reg;
  logic [1:0]  dec_low_reg;

  logic        req, wr, rd, dla, fen;
  logic [CW-1:0] cap;
  logic        tx_push, tx_pop, rx_push, rx_pop, tx_full, rx_full;
  logic        enc_raw, dec_in, dec_rx, rx_in, tx_busy;
  logic [3:0]  samp;

  // Bus decode: one access per request, answered the cycle after
  assign req = CYC_I && STB_I && !ack_reg;
  assign wr  = req && WE_I && SEL_I[0];
  assign rd  = req && !WE_I;
  assign dla = line_control_reg[`UBDI_LCR_DLA];
  assign fen = fctl_reg.fifo_enable;
  assign cap = fen ? CW'(DEPTH) : CW'(1);
  assign tx_full = tx_cnt_reg >= cap;
  assign rx_full = rx_cnt_reg >= cap;
  assign tx_push = wr && ADR_I == `UBDI_OFF_DATA && !dla && !tx_full;
  assign rx_pop  = rd && ADR_I == `UBDI_OFF_DATA && !dla && rx_cnt_reg != '0;
  assign ACK_O = ack_reg;
  assign DAT_O = rdata_reg;

  // Acknowledge
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  // Read data mux
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      rdata_reg <= '0;
    else if (rd)
    begin
      case (ADR_I)
        `UBDI_OFF_DATA:  rdata_reg <= dla ? {24'h0, divisor_reg[7:0]}
                                          : {24'h0, rx_mem[rx_rp_reg]};
        `UBDI_OFF_IEN:   rdata_reg <= dla ? {24'h0, divisor_reg[15:8]}
                                          : {24'h0, ien_reg};
        `UBDI_OFF_FIFO:  rdata_reg <= {31'h0, !TX_EMPTY_IRQ_O};
        `UBDI_OFF_LINE:  rdata_reg <= {24'h0, line_control_reg};
        `UBDI_OFF_LSTAT: rdata_reg <= {25'h0, tx_cnt_reg == '0 && !tx_busy,
                                       tx_cnt_reg == '0, 1'b0, frame_err_reg,
                                       1'b0, overrun_reg, rx_cnt_reg != '0};
        `UBDI_OFF_IRCTL: rdata_reg <= {24'h0, irctl_reg.narrow_pulse, 1'b0,
                                       irctl_reg.loop_back,
                                       irctl_reg.infrared_receive_enable,
                                       irctl_reg.ir_enable};
        default:         rdata_reg <= '0;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      line_control_reg <= '0;
      ien_reg          <= '0;
      fctl_reg         <= '0;
      irctl_reg        <= '0;
    end
    else if (wr)
    begin
      case (ADR_I)
        `UBDI_OFF_IEN:   if (!dla) ien_reg <= DAT_I[7:0];
        `UBDI_OFF_FIFO:  fctl_reg <= {DAT_I[7:4], DAT_I[`UBDI_FCR_DMA],
                                      DAT_I[`UBDI_FCR_FEN]};
        `UBDI_OFF_LINE:  line_control_reg <= DAT_I[7:0];
        `UBDI_OFF_IRCTL: irctl_reg <= {DAT_I[7:4], DAT_I[`UBDI_IRC_LOOP],
                                       DAT_I[`UBDI_IRC_RXEN], DAT_I[`UBDI_IRC_EN]};
        default:         ;
      endcase
    end
  end

  // Divisor latch, written only with the access bit set
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      divisor_reg <= `UBDI_DIV_RST;
    else if (wr && dla && ADR_I == `UBDI_OFF_DATA)
      divisor_reg[7:0] <= DAT_I[7:0];
    else if (wr && dla && ADR_I == `UBDI_OFF_IEN)
      divisor_reg[15:8] <= DAT_I[7:0];
  end

  // Baud divider down counter and end-of-count pulse
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      baud_divider_reg <= `UBDI_DIV_RST;
      tick_reg         <= 1'b0;
    end
    else if (wr && dla && (ADR_I == `UBDI_OFF_DATA || ADR_I == `UBDI_OFF_IEN))
    begin
      baud_divider_reg <= ADR_I == `UBDI_OFF_DATA ? {divisor_reg[15:8], DAT_I[7:0]}
                                                  : {DAT_I[7:0], divisor_reg[7:0]};
      tick_reg         <= 1'b0;
    end
    else if (baud_divider_reg <= `UBDI_DIV_END)
    begin
      baud_divider_reg <= divisor_reg;
      tick_reg         <= 1'b1;
    end
    else
    begin
      baud_divider_reg <= baud_divider_reg - 16'h0001;
      tick_reg         <= 1'b0;
    end
  end

  // Transmit FIFO
  always_ff @(posedge CLK_I)
  begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= DAT_I[7:0];
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I || (wr && ADR_I == `UBDI_OFF_FIFO && DAT_I[`UBDI_FCR_CLRTX]))
    begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + AW'(1);
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + AW'(1);
      tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
    end
  end

  // Receive FIFO and its error flags
  always_ff @(posedge CLK_I)
  begin
    if (rx_push && !rx_full)
      rx_mem[rx_wp_reg] <= rx_sh_reg;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I || (wr && ADR_I == `UBDI_OFF_FIFO && DAT_I[`UBDI_FCR_CLRRX]))
    begin
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      rx_cnt_reg <= '0;
    end
    else
    begin
      if (rx_push && !rx_full)
        rx_wp_reg <= rx_wp_reg + AW'(1);
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + AW'(1);
      rx_cnt_reg <= rx_cnt_reg + CW'(rx_push && !rx_full) - CW'(rx_pop);
    end
  end

  // Sticky line errors; a new error wins over the status read
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      overrun_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
    end
    else
    begin
      overrun_reg   <= (rx_push && rx_full) ||
                       (overrun_reg && !(rd && ADR_I == `UBDI_OFF_LSTAT));
      frame_err_reg <= (rx_st_reg == UBDI_STOP && tick_reg && rx_sub_reg == samp
                        && !rx_in) ||
                       (frame_err_reg && !(rd && ADR_I == `UBDI_OFF_LSTAT));
    end
  end

  // Interrupt and DMA requests
  assign TX_EMPTY_IRQ_O = ien_reg[`UBDI_IER_THRE] && tx_cnt_reg == '0;
  assign TX_DMA_REQ_O = fctl_reg.dma_enable &&
                        tx_cnt_reg <= CW'(fctl_reg.fifo_threshold);
  assign RX_DMA_REQ_O = fctl_reg.dma_enable && rx_cnt_reg != '0 &&
                        rx_cnt_reg >= CW'(fctl_reg.fifo_threshold);

  // Transmitter: start, eight data bits LSB first, stop
  assign tx_busy = tx_st_reg != UBDI_IDLE;
  assign tx_pop  = tx_st_reg == UBDI_IDLE && tick_reg && tx_cnt_reg != '0;
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      tx_st_reg   <= UBDI_IDLE;
      tx_sub_reg  <= '0;
      tx_bit_reg  <= '0;
      tx_sh_reg   <= '0;
      tx_line_reg <= 1'b1;
    end
    else if (tick_reg)
    begin
      tx_sub_reg <= tx_busy ? tx_sub_reg + 4'h1 : 4'h0;
      case (tx_st_reg)
        UBDI_IDLE:
          if (tx_pop)
          begin
            tx_sh_reg   <= tx_mem[tx_rp_reg];
            tx_line_reg <= 1'b0;
            tx_st_reg   <= UBDI_START;
          end
        UBDI_START:
          if (tx_sub_reg == `UBDI_TICKS_LAST)
          begin
            tx_line_reg <= tx_sh_reg[0];
            tx_bit_reg  <= '0;
            tx_st_reg   <= UBDI_DATA;
          end
        UBDI_DATA:
          if (tx_sub_reg == `UBDI_TICKS_LAST)
          begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            tx_line_reg <= tx_bit_reg == `UBDI_LAST_BIT ? 1'b1 : tx_sh_reg[1];
            if (tx_bit_reg == `UBDI_LAST_BIT)
              tx_st_reg <= UBDI_STOP;
          end
        UBDI_STOP:
          if (tx_sub_reg == `UBDI_TICKS_LAST)
            tx_st_reg <= UBDI_IDLE;
        default:
          tx_st_reg <= UBDI_IDLE;
      endcase
    end
  end
  assign SERIAL_OUT_O = tx_line_reg;

  // Infrared encoder: zero gives a pulse in slots 7 to 9 of 16
  assign enc_raw = irctl_reg.ir_enable && !tx_line_reg &&
                   tx_sub_reg >= `UBDI_IR_HI_FIRST &&
                   tx_sub_reg <= `UBDI_IR_HI_LAST;
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      opt_out_reg <= 1'b0;
    else
      opt_out_reg <= enc_raw && !irctl_reg.loop_back;
  end
  assign OPTICAL_OUT_O = opt_out_reg;

  // Decoder input: internal loopback or the optical pin
  assign dec_in = irctl_reg.loop_back ? enc_raw : OPTICAL_IN_I;

  // Pulse measure: narrow counter in hclk, width in baud clocks
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      opt_prev_reg <= 1'b0;
      np_cnt_reg   <= '0;
      np_ok_reg    <= 1'b0;
      width_reg    <= '0;
      dec_low_reg  <= '0;
    end
    else
    begin
      opt_prev_reg <= dec_in;
      if (dec_in && !opt_prev_reg)
      begin
        np_cnt_reg <= {irctl_reg.narrow_pulse, `UBDI_NP_LOW_BITS};
        np_ok_reg  <= irctl_reg.narrow_pulse == 4'h0;
        width_reg  <= '0;
      end
      else if (dec_in)
      begin
        if (np_cnt_reg != 6'h00)
          np_cnt_reg <= np_cnt_reg - 6'h01;
        // Flag lands by the last counted cycle, so width equal to count passes
        if (np_cnt_reg <= 6'h02)
          np_ok_reg <= 1'b1;
        if (tick_reg && width_reg != 3'h7)
          width_reg <= width_reg + 3'h1;
      end
      // Accept at the trailing edge: long enough and not over five clocks
      if (!dec_in && opt_prev_reg && np_ok_reg && width_reg <= `UBDI_IR_MAX_WIDTH
          && irctl_reg.infrared_receive_enable
          && (!tx_busy || irctl_reg.loop_back))
        dec_low_reg <= `UBDI_IR_LOW_TICKS;
      else if (tick_reg && dec_low_reg != 2'h0)
        dec_low_reg <= dec_low_reg - 2'h1;
    end
  end
  assign dec_rx = dec_low_reg == 2'h0;
  assign rx_in  = irctl_reg.ir_enable ? dec_rx : SERIAL_IN_I;
  assign samp   = irctl_reg.ir_enable ? `UBDI_SAMP_IR : `UBDI_SAMP_WIRE;

  // Receiver: sample each bit once per sixteen baud clocks
  assign rx_push = rx_st_reg == UBDI_STOP && tick_reg && rx_sub_reg == samp && rx_in;
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      rx_st_reg  <= UBDI_IDLE;
      rx_sub_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg  <= '0;
    end
    else if (tick_reg)
    begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
      case (rx_st_reg)
        UBDI_IDLE:
          if (!rx_in)
          begin
            rx_sub_reg <= 4'h1;
            rx_st_reg  <= UBDI_START;                  // Start confirmed at first sample
            rx_bit_reg <= '0;
          end
        UBDI_START:
          if (rx_sub_reg == samp)
            rx_st_reg <= rx_in ? UBDI_IDLE : UBDI_DATA;
        UBDI_DATA:
          if (rx_sub_reg == samp)
          begin
            rx_sh_reg  <= {rx_in, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == `UBDI_LAST_BIT)
              rx_st_reg <= UBDI_STOP;
          end
        UBDI_STOP:
          if (rx_sub_reg == samp)
            rx_st_reg <= UBDI_IDLE;
        default:
          rx_st_reg <= UBDI_IDLE;
      endcase
    end
  end
endmodule

/* logic/ubdi_consts.svh */
// Offsets, field positions, reset values and counts of the serial port block.
// Assumes inclusion by the principal design file only.
`ifndef UBDI_CONSTS_SVH
`define UBDI_CONSTS_SVH
// Word offsets on the register bus
`define UBDI_OFF_DATA      6'h00
`define UBDI_OFF_IEN       6'h04
`define UBDI_OFF_FIFO      6'h08
`define UBDI_OFF_LINE      6'h0c
`define UBDI_OFF_LSTAT     6'h14
`define UBDI_OFF_IRCTL     6'h20
// Field positions
`define UBDI_LCR_DLA       7
`define UBDI_IER_THRE      1
`define UBDI_IER_LINE_ERROR_IRQ_ENABLE      2
`define UBDI_FCR_FEN       0
`define UBDI_FCR_CLRRX     1
`define UBDI_FCR_CLRTX     2
`define UBDI_FCR_DMA       3
`define UBDI_IRC_EN        0
`define UBDI_IRC_RXEN      1
`define UBDI_IRC_LOOP      2
// Reset values and counts
`define UBDI_DIV_RST       16'h0002
`define UBDI_DIV_END       16'h0001
`define UBDI_TICKS_LAST    4'hf
`define UBDI_IR_HI_FIRST   4'h7
`define UBDI_IR_HI_LAST    4'h9
`define UBDI_IR_LOW_TICKS  2'h3
`define UBDI_IR_MAX_WIDTH  3'h5
`define UBDI_NP_LOW_BITS   2'h3
`define UBDI_SAMP_WIRE     4'h7
`define UBDI_SAMP_IR       4'h1
`define UBDI_LAST_BIT      3'h7
`endif

/* logic/ubdi_pkg.sv */
// Types shared by the serial port block.
// Assumes the constants header sits beside it.
package ubdi_pkg;
  // Serial engine states, one-hot
  typedef enum logic [3:0]
  {
    UBDI_IDLE  = 4'h1,
    UBDI_START = 4'h2,
    UBDI_DATA  = 4'h4,
    UBDI_STOP  = 4'h8
  } ubdi_state_e;
  // Infrared control fields
  typedef struct packed
  {
    logic [3:0] narrow_pulse;
    logic       loop_back;
    logic       infrared_receive_enable;
    logic       ir_enable;
  } ubdi_irctl_s;
  // FIFO control fields held after a write
  typedef struct packed
  {
    logic [3:0] fifo_threshold;
    logic       dma_enable;
    logic       fifo_enable;
  } ubdi_fctl_s;
endpackage

/* testbench/ubdi_top_asserts.sv */
// Port checker for the serial port top.
// Assumes a bind to ubdi_top; watches only its ports.
`timescale 1ns/1ns
module ubdi_top_asserts
(
  input wire logic        CLK_I,
  input wire logic        RESETN_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [5:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        SERIAL_IN_I,
  input wire logic        SERIAL_OUT_O,
  input wire logic        OPTICAL_IN_I,
  input wire logic        OPTICAL_OUT_O,
  input wire logic        TX_EMPTY_IRQ_O,
  input wire logic        TX_DMA_REQ_O,
  input wire logic        RX_DMA_REQ_O
);
  logic        wr;
  logic        dla_reg;
  logic        ien_reg;
  logic        dma_reg;
  logic        loop_reg;
  logic [15:0] div_reg;
  logic [4:0]  run_reg;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Write taken at this edge
  assign wr = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];
  // Shadow of the control bits software wrote
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      dla_reg <= 1'b0;
      ien_reg <= 1'b0;
      dma_reg <= 1'b0;
      loop_reg <= 1'b0;
      div_reg <= 16'h0002;
    end
    else if (wr)
    begin
      if (ADR_I == 6'h0c) dla_reg <= DAT_I[7];
      if (ADR_I == 6'h04 && !dla_reg) ien_reg <= DAT_I[1];
      if (ADR_I == 6'h08) dma_reg <= DAT_I[3];
      if (ADR_I == 6'h20) loop_reg <= DAT_I[2];
      if (ADR_I == 6'h00 && dla_reg) div_reg[7:0] <= DAT_I[7:0];
      if (ADR_I == 6'h04 && dla_reg) div_reg[15:8] <= DAT_I[7:0];
    end
  end
  // Cycles since the serial output last changed
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I) run_reg <= 5'h00;
    else if ($changed(SERIAL_OUT_O)) run_reg <= 5'h01;
    else run_reg <= run_reg + 5'h01;
  end
  property p_rst;
    disable iff (1'b0) !RESETN_I |=> SERIAL_OUT_O && !OPTICAL_OUT_O && !ACK_O
      && !TX_DMA_REQ_O && !RX_DMA_REQ_O && !TX_EMPTY_IRQ_O;
  endproperty
  property p_start;
    $fell(SERIAL_OUT_O) |-> (!SERIAL_OUT_O) [*8];
  endproperty
  property p_bit;
    $rose(SERIAL_OUT_O) && div_reg == 16'h0002 |-> run_reg == 5'h00;
  endproperty
  property p_pulse;
    $rose(OPTICAL_OUT_O) && div_reg == 16'h0002 |-> OPTICAL_OUT_O [*6] ##1 !OPTICAL_OUT_O;
  endproperty
  property p_loop;
    loop_reg [*2] |-> !OPTICAL_OUT_O;
  endproperty
  property p_wirq;
    wr && ADR_I == 6'h00 && !dla_reg |=> !TX_EMPTY_IRQ_O;
  endproperty
  property p_ien;
    !ien_reg |-> !TX_EMPTY_IRQ_O;
  endproperty
  property p_dma;
    (!dma_reg) [*2] |-> !TX_DMA_REQ_O && !RX_DMA_REQ_O;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  a_start: assert property (p_start) else $error("serial low too short");
  a_bit: assert property (p_bit) else $error("serial run not whole bits");
  a_pulse: assert property (p_pulse) else $error("optical pulse width");
  a_loop: assert property (p_loop) else $error("optical out in loopback");
  a_wirq: assert property (p_wirq) else $error("irq after data write");
  a_ien: assert property (p_ien) else $error("irq while disabled");
  a_dma: assert property (p_dma) else $error("dma request while off");
  c_txq: cover property ($rose(TX_DMA_REQ_O));
  c_rxq: cover property ($rose(RX_DMA_REQ_O));
  c_opt: cover property ($rose(OPTICAL_OUT_O));
endmodule

/* testbench/ubdi_line_model.sv */
// Far-side model: serial line and infrared transceiver.
// Assumes a divisor of TICK, so a bit is 16 * TICK clocks.
`timescale 1ns/1ns
module ubdi_line_model
#(
  parameter int TICK = 2
)
(
  input  wire logic clk_i,
  output logic      line_o,
  output logic      optical_o
);
  // Idle levels: wire high, light off
  initial
  begin
    line_o = 1'b1;
    optical_o = 1'b0;
  end
  // Wire frame, start, data LSB first, stop
  task automatic send_wire(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (16 * TICK - 1) @(posedge clk_i);
    end
  endtask
  // Light frame, w-tick pulse after 7 dark ticks per zero
  task automatic send_ir(input logic [7:0] b, input int w);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 160; i++)
    begin
      @(posedge clk_i);
      optical_o <= !f[i / 16] && i % 16 >= 7 && i % 16 < 7 + w;
      repeat (TICK - 1) @(posedge clk_i);
    end
  endtask
endmodule

/* testbench/ubdi_top_bench.sv */
// Self-checking bench for the serial port top.
// Assumes the line model and checker compiled before it.
`timescale 1ns/1ns
module ubdi_top_bench;
  logic        clk, rstn, cyc, stb, we, ack, sin, sout, oin, oout, irq, txq, rxq;
  logic [3:0]  sel;
  logic [5:0]  adr;
  logic [31:0] wdat, dout, rd;
  int          mismatches, compares, cycles, hi_cnt, h0;
  ubdi_top #(.DEPTH(16)) dut
  (
    .CLK_I(clk), .RESETN_I(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(dout), .ACK_O(ack), .SERIAL_IN_I(sin),
    .SERIAL_OUT_O(sout), .OPTICAL_IN_I(oin), .OPTICAL_OUT_O(oout),
    .TX_EMPTY_IRQ_O(irq), .TX_DMA_REQ_O(txq), .RX_DMA_REQ_O(rxq)
  );
  ubdi_line_model #(.TICK(2)) line (.clk_i(clk), .line_o(sin), .optical_o(oin));
  // Clock, timeout and optical-high counter
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (oout === 1'b1) hi_cnt++;
    if (cycles > 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk("ack", 1, ack);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    wb(0, 6'h14, 8'h00);
    while (rd[6] !== 1'b1 && n < 1000)
    begin
      wb(0, 6'h14, 8'h00);
      n++;
    end
  endtask
  // Follow one wire frame at mid-bit
  task automatic tx_check(input logic [7:0] b);
    int n;
    n = 0;
    while (sout !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    repeat (16) @(posedge clk);
    chk("start bit", 0, sout);
    for (int i = 0; i < 9; i++)
    begin
      repeat (32) @(posedge clk);
      chk("frame bit", i < 8 ? b[i] : 1'b1, sout);
    end
  endtask
  task automatic t_reset();
    chk("reset pins", 5'b10000, {sout, oout, txq, rxq, irq});
    wb(0, 6'h14, 8'h00);
    chk("line status", 32'h60, rd);
  endtask
  task automatic t_div();
    wb(1, 6'h04, 8'h04);
    wb(1, 6'h0c, 8'h80);
    wb(0, 6'h04, 8'h00);
    chk("divisor high", 0, rd);
    wb(0, 6'h00, 8'h00);
    chk("divisor low", 2, rd);
    wb(1, 6'h00, 8'h02);
    wb(1, 6'h04, 8'h00);
    wb(1, 6'h0c, 8'h00);
    wb(0, 6'h04, 8'h00);
    chk("enables", 4, rd);
  endtask
  task automatic t_tx();
    wb(1, 6'h08, 8'h01);
    wb(1, 6'h04, 8'h06);
    chk("irq on enable", 1, irq);
    wb(1, 6'h00, 8'ha5);
    wb(1, 6'h00, 8'h3c);
    chk("irq after write", 0, irq);
    tx_check(8'ha5);
    tx_check(8'h3c);
    wait_idle();
    chk("irq drained", 1, irq);
    wb(1, 6'h04, 8'h04);
  endtask
  // FIFO off: one byte waits, a third write is dropped
  task automatic t_one();
    wb(1, 6'h08, 8'h00);
    wb(1, 6'h00, 8'h81);
    wb(1, 6'h00, 8'h42);
    wb(1, 6'h00, 8'h24);
    tx_check(8'h81);
    tx_check(8'h42);
    wb(0, 6'h14, 8'h00);
    chk("third byte dropped", 2'b01, rd[6:5]);
    wait_idle();
  endtask
  task automatic t_dma();
    wb(1, 6'h08, 8'h29);
    chk("requests empty", 2'b10, {txq, rxq});
    for (int i = 0; i < 5; i++) wb(1, 6'h00, i[7:0]);
    chk("tx request full", 0, txq);
    wait_idle();
    chk("tx request drained", 1, txq);
    line.send_wire(8'h11);
    repeat (8) @(posedge clk);
    chk("rx request one", 0, rxq);
    line.send_wire(8'h22);
    repeat (8) @(posedge clk);
    chk("rx request two", 1, rxq);
    for (int i = 0; i < 2; i++)
    begin
      wb(0, 6'h14, 8'h00);
      wb(0, 6'h00, 8'h00);
      chk("rx byte", i == 0 ? 8'h11 : 8'h22, rd);
    end
    chk("rx request low", 0, rxq);
    wb(1, 6'h08, 8'h21);
    chk("requests off", 0, {txq, rxq});
  endtask
  task automatic t_ir();
    wb(1, 6'h20, 8'h01);
    h0 = hi_cnt;
    wb(1, 6'h00, 8'hf0);
    wait_idle();
    chk("light cycles", 30, hi_cnt - h0);
    wb(1, 6'h20, 8'h07);
    h0 = hi_cnt;
    wb(1, 6'h00, 8'h5a);
    wait_idle();
    repeat (8) @(posedge clk);
    chk("loop pin", 0, hi_cnt - h0);
    wb(0, 6'h14, 8'h00);
    wb(0, 6'h00, 8'h00);
    chk("loop byte", 8'h5a, rd);
  endtask
  task automatic t_irrx();
    for (int i = 0; i < 3; i++)
    begin
      wb(1, 6'h20, i == 2 ? 8'hf3 : 8'h03);
      line.send_ir(8'h96, i == 1 ? 8 : 3);
      repeat (8) @(posedge clk);
      wb(0, 6'h14, 8'h00);
      chk("ir ready", i == 0, rd[0]);
      if (i == 0) wb(0, 6'h00, 8'h00);
      if (i == 0) chk("ir byte", 8'h96, rd);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'h1;
    {mismatches, compares, cycles, hi_cnt} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_div();
    t_tx();
    t_one();
    t_dma();
    t_ir();
    t_irrx();
    print_verdict();
  end
endmodule
bind ubdi_top ubdi_top_asserts chk_u
(
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .SERIAL_IN_I(SERIAL_IN_I), .SERIAL_OUT_O(SERIAL_OUT_O), .OPTICAL_IN_I(OPTICAL_IN_I),
  .OPTICAL_OUT_O(OPTICAL_OUT_O), .TX_EMPTY_IRQ_O(TX_EMPTY_IRQ_O),
  .TX_DMA_REQ_O(TX_DMA_REQ_O), .RX_DMA_REQ_O(RX_DMA_REQ_O)
);
